//--- rtl/csi_rx_error_monitor.sv
/*
 * error monitor and header capture for a four-lane camera serial receiver,
 * with an avalon-mm register slave and one level interrupt.
 * assumes all event and header inputs come from receiver logic clocked by
 * mclk_in; events are one-cycle pulses, header fields are valid with
 * hdr_valid_in.
 */
// Local design decision: register access over Avalon-MM.
// What this block does
// - 8-bit errored packet tally, read clears
// - status bit 3: short line, read clears
// - status bit 2: payload checksum fault, read clears
// - status bit 1: header double-bit fault, read clears
// - status bit 0: header single-bit fault, read clears
// - lane sync single-bit fault: bit 7/3
// - lane sync multi-bit fault: bit 6/2
// - lane request-entry control fault: bit 5/1
// - two lane registers, odd lane upper nibble
// - clock lane control fault at bit 1
// - virtual channel captured in bits 7:6
// - data type captured in bits 5:0
// - word count low byte register
// - word count high byte register, adjacent
// - header ecc in bits 5:0, bit 6 zero
// - bit 7 flags line length change
`timescale 1ns/1ps
`default_nettype none

module csi_rx_error_monitor
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,

    // avalon-mm slave
    input wire logic [csi_err_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [csi_err_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [csi_err_pkg::BE_W-1:0] avs_byteenable_in,
    output logic [csi_err_pkg::DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,

    // packet level events
    input wire logic errored_packet_in,
    input wire logic short_line_in,
    input wire logic payload_sum_fault_in,
    input wire logic header_double_fault_in,
    input wire logic header_single_fault_in,
    input wire logic line_change_in,

    // lane level events, one bit per data lane
    input wire logic [csi_err_pkg::LANES-1:0] sync_correctable_in,
    input wire logic [csi_err_pkg::LANES-1:0] sync_uncorrectable_in,
    input wire logic [csi_err_pkg::LANES-1:0] request_fault_in,
    input wire logic clock_lane_request_fault_in,

    // long packet header
    input wire logic hdr_valid_in,
    input wire logic [1:0] hdr_virtual_channel_in,
    input wire logic [5:0] hdr_data_type_in,
    input wire logic [15:0] hdr_word_count_in,
    input wire logic [5:0] hdr_ecc_in,

    // interrupt
    output logic irq_out
);

    typedef struct packed
    {
        // bus answer
        logic ack;
        logic [csi_err_pkg::DATA_W-1:0] rdata;

        // packet tally and flags
        logic [7:0] tally;
        logic [3:0] pkt_flags;

        // per-lane and clock lane flags
        logic [csi_err_pkg::LANES-1:0] sync_corr;
        logic [csi_err_pkg::LANES-1:0] sync_uncorr;
        logic [csi_err_pkg::LANES-1:0] req_fault;
        logic clk_fault;

        // header capture
        logic [1:0] vc;
        logic [5:0] dt;
        logic [15:0] wc;
        logic [5:0] ecc;
        logic line_change;

        // interrupt
        logic [7:0] irq_status;
        logic [7:0] irq_enable;
        logic irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // register index of a byte address
    function automatic logic [7:0] reg_index(input logic [csi_err_pkg::ADDR_W-1:0] addr);
        reg_index = addr[csi_err_pkg::IDX_LSB +: 8];
    endfunction

    // one lane nibble: correctable, uncorrectable, control fault, reserved zero
    function automatic logic [3:0] lane_nibble(input logic corr, input logic uncorr, input logic fault);
        logic [3:0] n;
        n = 4'h0;
        n[csi_err_pkg::LANE_CORR_BIT] = corr;
        n[csi_err_pkg::LANE_UNCORR_BIT] = uncorr;
        n[csi_err_pkg::LANE_FAULT_BIT] = fault;
        lane_nibble = n;
    endfunction

    // clear-on-read strobe for one register
    function automatic logic read_hit(input logic rd, input logic [7:0] at, input logic [7:0] target);
        read_hit = rd && (at == target);
    endfunction

    // write strobe for one register; only the low byte lane carries data
    function automatic logic write_hit(input logic wr, input logic be0, input logic [7:0] at,
                                       input logic [7:0] target);
        write_hit = wr && be0 && (at == target);
    endfunction

    logic [7:0] lane_low;
    logic [7:0] lane_high;
    logic [15:0] lane_bytes;

    genvar g;
    generate
        for (g = 0; g < csi_err_pkg::LANES; g++)
        begin : g_lane
            assign lane_bytes[g*4 +: 4] = lane_nibble(s_r.sync_corr[g], s_r.sync_uncorr[g],
                                                      s_r.req_fault[g]);
        end
    endgenerate

    // lanes 0/1 in the first byte, 2/3 in the second, odd lane on top
    assign lane_low = lane_bytes[7:0];
    assign lane_high = lane_bytes[15:8];

    logic take_rd;
    logic take_wr;
    logic [7:0] idx;
    logic [7:0] rd_byte;
    logic [7:0] base_tally;
    logic [7:0] events;
    logic [7:0] clr_mask;

    always_comb
    begin
        s_nxt = s_r;
        idx = reg_index(avs_address_in);
        take_rd = avs_read_in & ~s_r.ack;
        take_wr = avs_write_in & ~avs_read_in & ~s_r.ack;

        // one wait state: request taken at the first edge, answered at the next
        s_nxt.ack = take_rd | take_wr;

        // read data, unmapped and write-only registers read zero
        rd_byte = csi_err_pkg::RST_BYTE;
        unique case (idx)
            csi_err_pkg::IDX_TALLY:
            begin
                rd_byte = s_r.tally;
            end
            csi_err_pkg::IDX_PKT_FLAGS:
            begin
                rd_byte = {4'h0, s_r.pkt_flags};
            end
            csi_err_pkg::IDX_LANE_LOW:
            begin
                rd_byte = lane_low;
            end
            csi_err_pkg::IDX_LANE_HIGH:
            begin
                rd_byte = lane_high;
            end
            csi_err_pkg::IDX_CLK_LANE:
            begin
                rd_byte = {6'h00, s_r.clk_fault, 1'b0};
            end
            csi_err_pkg::IDX_HDR_CHAN_TYPE:
            begin
                rd_byte = {s_r.vc, s_r.dt};
            end
            csi_err_pkg::IDX_WC_LOW:
            begin
                rd_byte = s_r.wc[7:0];
            end
            csi_err_pkg::IDX_WC_HIGH:
            begin
                rd_byte = s_r.wc[15:8];
            end
            csi_err_pkg::IDX_HDR_CHECK:
            begin
                rd_byte = {s_r.line_change, 1'b0, s_r.ecc};
            end
            csi_err_pkg::IDX_IRQ_STATUS:
            begin
                rd_byte = s_r.irq_status;
            end
            csi_err_pkg::IDX_IRQ_ENABLE:
            begin
                rd_byte = s_r.irq_enable;
            end
            // write-only clear and unmapped indices read zero
            default:
            begin
                rd_byte = csi_err_pkg::RST_BYTE;
            end
        endcase
        // readdata is registered and held, so a slow master still sees it
        if (take_rd)
        begin
            s_nxt.rdata = {24'h000000, rd_byte};
        end

        // tally: read clears, a same-cycle error still counts
        // the clear acts on the old count, so an error in the read cycle is kept
        base_tally = read_hit(take_rd, idx, csi_err_pkg::IDX_TALLY) ? csi_err_pkg::RST_BYTE : s_r.tally;
        s_nxt.tally = base_tally;
        if (errored_packet_in && base_tally != csi_err_pkg::TALLY_MAX)
        begin
            s_nxt.tally = base_tally + csi_err_pkg::TALLY_STEP;
        end

        // packet flags: cleared by read, set wins over the clear
        if (read_hit(take_rd, idx, csi_err_pkg::IDX_PKT_FLAGS))
        begin
            s_nxt.pkt_flags = 4'h0;
        end
        if (short_line_in)
        begin
            s_nxt.pkt_flags[csi_err_pkg::PKT_SHORT_BIT] = 1'b1;
        end
        if (payload_sum_fault_in)
        begin
            s_nxt.pkt_flags[csi_err_pkg::PKT_SUM_BIT] = 1'b1;
        end
        if (header_double_fault_in)
        begin
            s_nxt.pkt_flags[csi_err_pkg::PKT_DOUBLE_BIT] = 1'b1;
        end
        if (header_single_fault_in)
        begin
            s_nxt.pkt_flags[csi_err_pkg::PKT_SINGLE_BIT] = 1'b1;
        end

        // lane flags are sticky; a read of the pair's register clears that pair
        if (read_hit(take_rd, idx, csi_err_pkg::IDX_LANE_LOW))
        begin
            s_nxt.sync_corr[1:0] = 2'b00;
            s_nxt.sync_uncorr[1:0] = 2'b00;
            s_nxt.req_fault[1:0] = 2'b00;
        end
        if (read_hit(take_rd, idx, csi_err_pkg::IDX_LANE_HIGH))
        begin
            s_nxt.sync_corr[3:2] = 2'b00;
            s_nxt.sync_uncorr[3:2] = 2'b00;
            s_nxt.req_fault[3:2] = 2'b00;
        end
        s_nxt.sync_corr = s_nxt.sync_corr | sync_correctable_in;
        s_nxt.sync_uncorr = s_nxt.sync_uncorr | sync_uncorrectable_in;
        s_nxt.req_fault = s_nxt.req_fault | request_fault_in;

        if (read_hit(take_rd, idx, csi_err_pkg::IDX_CLK_LANE))
        begin
            s_nxt.clk_fault = 1'b0;
        end
        if (clock_lane_request_fault_in)
        begin
            s_nxt.clk_fault = 1'b1;
        end

        // header capture, overwritten by every long packet header
        if (hdr_valid_in)
        begin
            s_nxt.vc = hdr_virtual_channel_in;
            s_nxt.dt = hdr_data_type_in;
            s_nxt.wc = hdr_word_count_in;
            s_nxt.ecc = hdr_ecc_in;
        end

        // line change is sticky so a fault between reads is not missed
        if (read_hit(take_rd, idx, csi_err_pkg::IDX_HDR_CHECK))
        begin
            s_nxt.line_change = 1'b0;
        end
        if (line_change_in)
        begin
            s_nxt.line_change = 1'b1;
        end

        // interrupt enable, low byte lane only
        if (write_hit(take_wr, avs_byteenable_in[0], idx, csi_err_pkg::IDX_IRQ_ENABLE))
        begin
            s_nxt.irq_enable = avs_writedata_in[7:0];
        end

        // interrupt status: write one to clear, a new event wins
        events = 8'h00;
        events[csi_err_pkg::IRQ_SINGLE] = header_single_fault_in;
        events[csi_err_pkg::IRQ_DOUBLE] = header_double_fault_in;
        events[csi_err_pkg::IRQ_SUM] = payload_sum_fault_in;
        events[csi_err_pkg::IRQ_SHORT] = short_line_in;
        events[csi_err_pkg::IRQ_SYNC_CORR] = |sync_correctable_in;
        events[csi_err_pkg::IRQ_SYNC_UNCORR] = |sync_uncorrectable_in;
        events[csi_err_pkg::IRQ_REQ_FAULT] = (|request_fault_in) | clock_lane_request_fault_in;
        events[csi_err_pkg::IRQ_LINE_CHANGE] = line_change_in;
        clr_mask = 8'h00;
        if (write_hit(take_wr, avs_byteenable_in[0], idx, csi_err_pkg::IDX_IRQ_CLEAR))
        begin
            clr_mask = avs_writedata_in[7:0];
        end
        s_nxt.irq_status = (s_r.irq_status & ~clr_mask) | events;
        // irq from next state: one cycle after the cause, glitch-free level
        s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_enable);
    end

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // waitrequest drops in the cycle after the request is taken
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~s_r.ack;
    assign avs_readdata_out = s_r.rdata;
    assign irq_out = s_r.irq;

endmodule

`default_nettype wire

//--- rtl/csi_err_pkg.sv
/*
 * constants for the camera receiver error monitor: register indices,
 * field positions, reset values and bus geometry.
 * assumes the monitor sits on a 32-bit avalon-mm bus with byte addresses,
 * one aligned word per 8-bit register, byte address = 4 * index.
 */
package csi_err_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned LANES = 4;

    // register indices
    localparam logic [7:0] IDX_TALLY = 8'h5c;
    localparam logic [7:0] IDX_PKT_FLAGS = 8'h5d;
    localparam logic [7:0] IDX_LANE_LOW = 8'h5e;
    localparam logic [7:0] IDX_LANE_HIGH = 8'h5f;
    localparam logic [7:0] IDX_CLK_LANE = 8'h60;
    localparam logic [7:0] IDX_HDR_CHAN_TYPE = 8'h61;
    localparam logic [7:0] IDX_WC_LOW = 8'h62;
    localparam logic [7:0] IDX_WC_HIGH = 8'h63;
    localparam logic [7:0] IDX_HDR_CHECK = 8'h64;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h65;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h66;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h67;

    // packet_error_flags fields
    localparam int unsigned PKT_SINGLE_BIT = 0;
    localparam int unsigned PKT_DOUBLE_BIT = 1;
    localparam int unsigned PKT_SUM_BIT = 2;
    localparam int unsigned PKT_SHORT_BIT = 3;

    // per-lane nibble fields; odd lanes sit in the upper nibble
    localparam int unsigned LANE_CORR_BIT = 3;
    localparam int unsigned LANE_UNCORR_BIT = 2;
    localparam int unsigned LANE_FAULT_BIT = 1;
    localparam int unsigned UPPER_NIBBLE = 4;

    // clock lane and header check fields
    localparam int unsigned CLK_FAULT_BIT = 1;
    localparam int unsigned LINE_CHANGE_BIT = 7;
    localparam int unsigned VC_LSB = 6;

    // interrupt status / enable / clear layout
    localparam int unsigned IRQ_SINGLE = 0;
    localparam int unsigned IRQ_DOUBLE = 1;
    localparam int unsigned IRQ_SUM = 2;
    localparam int unsigned IRQ_SHORT = 3;
    localparam int unsigned IRQ_SYNC_CORR = 4;
    localparam int unsigned IRQ_SYNC_UNCORR = 5;
    localparam int unsigned IRQ_REQ_FAULT = 6;
    localparam int unsigned IRQ_LINE_CHANGE = 7;

    // reset values and limits
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] TALLY_MAX = 8'hff;
    localparam logic [7:0] TALLY_STEP = 8'h01;

endpackage

//--- sim/csi_err_sva.sv
/* assertions on the error monitor ports.
   assumes one clock domain and an async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module csi_err_sva
(
    // clock, reset and bus
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // receiver side
    input wire logic errored_packet_in,
    input wire logic hdr_valid_in,
    input wire logic [1:0] hdr_virtual_channel_in,
    input wire logic [5:0] hdr_data_type_in,
    input wire logic [15:0] hdr_word_count_in
);
    typedef struct packed {logic [7:0] tally; logic [23:0] cap;} mon_t;
    mon_t mon_r;
    mon_t mon_nxt;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_rd(logic [7:0] i);
        avs_read_in && avs_waitrequest_out && avs_address_in[9:2] == i;
    endsequence
    // shadow of the tally and the last header, read clear wins only over old count
    always_comb
    begin
        mon_nxt = mon_r;
        if (errored_packet_in && mon_r.tally != 8'hff)
            mon_nxt.tally = mon_r.tally + 8'h01;
        if (avs_read_in && avs_waitrequest_out && avs_address_in[9:2] == 8'h5c)
            mon_nxt.tally = {7'h00, errored_packet_in};
        if (hdr_valid_in)
            mon_nxt.cap = {hdr_virtual_channel_in, hdr_data_type_in, hdr_word_count_in};
    end
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            mon_r <= '0;
        else
            mon_r <= mon_nxt;
    end
    a_one_wait_state: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("request not answered after one wait state");
    a_idle_no_wait: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("waitrequest high while idle");
    a_upper_bytes_zero: assert property (avs_readdata_out[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");
    a_status_high_zero: assert property (s_rd(8'h5d) |=> avs_readdata_out[7:4] == 4'h0)
        else $error("status upper nibble not zero");
    a_lane_reserved_zero: assert property ((s_rd(8'h5e) or s_rd(8'h5f)) |=> !avs_readdata_out[4] && !avs_readdata_out[0])
        else $error("lane register reserved bit set");
    a_clock_lane_zero: assert property (s_rd(8'h60) |=> {avs_readdata_out[7:2], avs_readdata_out[0]} == 7'h00)
        else $error("clock lane register reserved bit set");
    a_check_bit_zero: assert property (s_rd(8'h64) |=> !avs_readdata_out[6])
        else $error("header check bit 6 set");
    a_header_type_match: assert property (s_rd(8'h61) |=> avs_readdata_out[7:0] == $past(mon_r.cap[23:16]))
        else $error("channel and type differ from last header");
    a_count_low_match: assert property (s_rd(8'h62) |=> avs_readdata_out[7:0] == $past(mon_r.cap[7:0]))
        else $error("word count low byte differs from last header");
    a_tally_value_match: assert property (s_rd(8'h5c) |=> avs_readdata_out[7:0] == $past(mon_r.tally))
        else $error("tally differs from errored packet count");
endmodule
bind csi_rx_error_monitor csi_err_sva u_sva (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .errored_packet_in(errored_packet_in), .hdr_valid_in(hdr_valid_in),
    .hdr_virtual_channel_in(hdr_virtual_channel_in), .hdr_data_type_in(hdr_data_type_in),
    .hdr_word_count_in(hdr_word_count_in));
`default_nettype wire

//--- sim/sensor_link_model.sv
/* sensor-side source: one-cycle event pulses and long packet headers.
   assumes the monitor samples on the rising edge of mclk_in. */
`timescale 1ns/1ps
`default_nettype none
module sensor_link_model
(
    // clock
    input wire logic mclk_in,
    // events and header word
    output logic [18:0] ev_out,
    output logic [30:0] hdr_out
);
    initial
    begin
        ev_out = 19'h0;
        hdr_out = 31'h0;
    end
    // stale header fields are inverted so a late capture cannot pass by luck
    task automatic send(input logic [18:0] ev, input logic [30:0] hdr);
        @(posedge mclk_in);
        ev_out <= ev;
        hdr_out <= hdr;
        @(posedge mclk_in);
        ev_out <= 19'h0;
        hdr_out <= {1'b0, ~hdr[29:0]};
    endtask
endmodule
`default_nettype wire

//--- sim/csi_rx_error_monitor_tb.sv
/* self-checking bench for the error monitor over its avalon-mm port.
   assumes the sensor model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module csi_rx_error_monitor_tb;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [9:0] adr = 10'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic irq;
    logic [18:0] ev;
    logic [30:0] hdr;
    logic [30:0] h;
    int errors = 0;
    int n_tests = 0;
    always #5 mclk_in = ~mclk_in;
    sensor_link_model snd (.mclk_in(mclk_in), .ev_out(ev), .hdr_out(hdr));
    csi_rx_error_monitor DUT (.mclk_in(mclk_in), .rstn_in(rstn_in), .avs_address_in(adr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdat), .avs_byteenable_in(4'h1),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .errored_packet_in(ev[4]),
        .short_line_in(ev[3]), .payload_sum_fault_in(ev[2]), .header_double_fault_in(ev[1]),
        .header_single_fault_in(ev[0]), .line_change_in(ev[5]), .sync_correctable_in(ev[9:6]),
        .sync_uncorrectable_in(ev[13:10]), .request_fault_in(ev[17:14]),
        .clock_lane_request_fault_in(ev[18]), .hdr_valid_in(hdr[30]), .hdr_virtual_channel_in(hdr[29:28]),
        .hdr_data_type_in(hdr[27:22]), .hdr_word_count_in(hdr[21:6]), .hdr_ecc_in(hdr[5:0]), .irq_out(irq));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk_in);
        adr <= {idx, 2'b00};
        rd_en <= !wr;
        wr_en <= wr;
        wdat <= {24'h0, d};
        do @(posedge mclk_in); while (wreq !== 1'b0);
        q = rdat[7:0];
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] q;
        bus(idx, 1'b0, 8'h00, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(idx, 1'b1, d, q);
    endtask
    task automatic irq_chk(input logic e);
        @(posedge mclk_in);
        chk({7'h0, irq}, {7'h0, e});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        for (int i = 8'h5c; i <= 8'h67; i++)
            rd_chk(8'(i), 8'h00);
        rd_chk(8'h10, 8'h00);
        wr(8'h5c, 8'h55);
        rd_chk(8'h5c, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            snd.send(19'(1 << i), 31'h0);
            rd_chk(8'h5d, 8'(1 << i));
            rd_chk(8'h5d, 8'h00);
        end
        repeat (3) snd.send(19'h10, 31'h0);
        rd_chk(8'h5c, 8'h03);
        rd_chk(8'h5c, 8'h00);
        // past the top of the count, no wrap expected
        repeat (260) snd.send(19'h10, 31'h0);
        rd_chk(8'h5c, 8'hff);
        for (int l = 0; l < 4; l++)
            for (int k = 0; k < 3; k++)
            begin
                snd.send(19'(1 << (6 + 4 * k + l)), 31'h0);
                rd_chk(8'(8'h5e + l / 2), 8'(1 << (4 * (l % 2) + 3 - k)));
            end
        snd.send(19'h40000, 31'h0);
        rd_chk(8'h60, 8'h02);
        for (int i = 0; i < 2; i++)
        begin
            h = i ? {1'b1, 2'h1, 6'h1e, 16'hbe3c, 6'h2a} : {1'b1, 2'h2, 6'h2b, 16'h1234, 6'h15};
            snd.send(i ? 19'h20 : 19'h0, h);
            rd_chk(8'h61, h[29:22]);
            rd_chk(8'h62, h[13:6]);
            rd_chk(8'h63, h[21:14]);
            rd_chk(8'h64, {i[0], 1'b0, h[5:0]});
        end
        wr(8'h67, 8'hff);
        wr(8'h66, 8'h08);
        rd_chk(8'h66, 8'h08);
        snd.send(19'h8, 31'h0);
        irq_chk(1'b1);
        wr(8'h66, 8'h00);
        irq_chk(1'b0);
        wr(8'h66, 8'h08);
        irq_chk(1'b1);
        rd_chk(8'h65, 8'h08);
        wr(8'h67, 8'h08);
        irq_chk(1'b0);
        rd_chk(8'h65, 8'h00);
        rd_chk(8'h5d, 8'h08);
        tally_and_finish();
    end
endmodule
`default_nettype wire
